// >>> vga_params.svh
// constants for the gain configuration register bank
`ifndef VGA_PARAMS_SVH
`define VGA_PARAMS_SVH

// ----------------------------------------------------------------------
// register addresses and frame layout
// ----------------------------------------------------------------------
`define VGA_REG_CTRL        5'h00
`define VGA_REG_EN          5'h01
`define VGA_REG_SET         5'h02
`define VGA_REG_GAIN        5'h03
`define VGA_CHIP_ADDR       3'h6
`define VGA_FRAME_BITS      6'h20
`define VGA_DATA_LSB        8
`define VGA_ADDR_LSB        3

// ----------------------------------------------------------------------
// reset values and soft reset words
// ----------------------------------------------------------------------
`define VGA_EN_RST          2'h3
`define VGA_SET_RST         8'h15
`define VGA_GAIN_RST        9'h000
`define VGA_RDADDR_RST      5'h00
`define VGA_SR_ARM          24'h00_0020
`define VGA_SR_FIRE         24'h00_0000
`define VGA_SYNC_RST        10'h002

// ----------------------------------------------------------------------
// gain decoder constants: amounts in half-dB units, then one-hot first stage select codes
// ----------------------------------------------------------------------
`define VGA_GAIN_MAX        7'h50
`define VGA_S1_20DB_HALF    7'h28
`define VGA_S1_10DB_HALF    7'h14
`define VGA_S3_10DB_HALF    7'h14
`define VGA_S1_0DB          3'h1
`define VGA_S1_10DB         3'h2
`define VGA_S1_20DB         3'h4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define VGA_CLK_MHZ         125
`define VGA_CLK_PERIOD_NS   8
`define VGA_POR_TIME_US     250
`define VGA_POR_CYCLES      (`VGA_POR_TIME_US * `VGA_CLK_MHZ)
`define VGA_SKEW_NS         10
`define VGA_DEGLITCH_CYCLES ((`VGA_SKEW_NS + `VGA_CLK_PERIOD_NS - 1) / `VGA_CLK_PERIOD_NS)

`endif

// >>> vga_pkg.sv
// types shared by the gain configuration register bank
package vga_pkg;

    // ------------------------------------------------------------------
    // stage settings, laid out like the raw nine-bit gain field
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       s3_10db;
        logic [2:0] s1_sel;
        logic [4:0] s2_half_db;
    } stage_t;

    typedef struct packed {
        logic       drop_deglitch;
        logic       bypass_decode;
        logic       gain_from_spi;
        logic       input_termination_low;
        logic [1:0] drv_bias;
        logic [1:0] amp_bias;
    } settings_t;

    typedef struct packed {
        logic q_en;
        logic i_en;
    } enables_t;

    typedef enum logic [1:0] {
        ST_POR    = 2'b00,
        ST_IDLE   = 2'b01,
        ST_SHIFT  = 2'b11,
        ST_COMMIT = 2'b10
    } link_state_t;

endpackage

// >>> gain_decoder.sv
// gain decoder: seven-bit half-dB code to three stage settings
`timescale 1ns/1ps
`include "vga_params.svh"

module gain_decoder
    import vga_pkg::*;
(
    input  wire logic [6:0] code,
    output stage_t          stage
);

    logic [6:0] half;
    logic [6:0] rem1;
    logic [6:0] rem2;

    // ------------------------------------------------------------------
    // front stage first, then output stage, remainder on middle stage
    // ------------------------------------------------------------------
    always_comb begin
        half = (code > `VGA_GAIN_MAX) ? `VGA_GAIN_MAX : code;
        stage.s1_sel = `VGA_S1_0DB;
        rem1 = half;
        if (half >= `VGA_S1_20DB_HALF) begin
            stage.s1_sel = `VGA_S1_20DB;
            rem1 = half - `VGA_S1_20DB_HALF;
        end else if (half >= `VGA_S1_10DB_HALF) begin
            stage.s1_sel = `VGA_S1_10DB;
            rem1 = half - `VGA_S1_10DB_HALF;
        end
        stage.s3_10db = (rem1 >= `VGA_S3_10DB_HALF);
        rem2 = stage.s3_10db ? (rem1 - `VGA_S3_10DB_HALF) : rem1;
        stage.s2_half_db = rem2[4:0];
    end

endmodule

// >>> vga_gain_config_registers.sv
// serial configuration registers and gain selection for a dual-channel vga
//
// Behaviour
// [R1] three registers at 01h-03h via serial port
// [R2] enable bit 0 switches I; resets 1
// [R3] enable bit 1 switches Q; resets 1
// [R4] settings 1:0 amplifier current, resets 01
// [R5] host uses amplifier current 01 or 10; the testbench also writes 00 and 11
// [R6] settings 3:2 output stage current, resets 01
// [R7] host uses output stage current 10; the testbench also writes 00, 01 and 11
// [R8] settings bit 4 termination select, resets 1
// [R9] settings bit 5 picks gain source, resets 0
// [R10] settings bit 6 bypasses decoder, serial only
// [R11] settings bit 7 disables deglitching, resets 0
// [R12] pin source ignores gain register entirely
// [R13] decoded code 0..80 half-dB, resets zero
// [R14] same gain to I and Q
// [R15] undecoded nine-bit raw stage field
// [R16] raw 7:5 selects first stage 0/10/20
// [R17] raw bit 8 third stage 0/10
// [R18] raw 4:0 second stage half-dB steps
// [R19] pin codes always pass the decoder
// [R20] host drives seven-bit code on pins
// [R21] soft reset 20h then 00h; power-on default
// [R22] frame: 24 data, 5 address, 3 chip
// [R23] new values apply at frame end only
// [R24] spare and unused bits ignored
`timescale 1ns/1ps
`include "vga_params.svh"

module vga_gain_config_registers
    import vga_pkg::*;
#(
    parameter int POR_CYCLES      = `VGA_POR_CYCLES,
    parameter int DEGLITCH_CYCLES = `VGA_DEGLITCH_CYCLES
)(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       sck,
    input  wire logic       sen_n,
    input  wire logic       sdi,
    input  wire logic [6:0] gain_pins,
    output logic            sdo_o,
    output logic            sdo_oe,
    output logic            i_chan_en,
    output logic            q_chan_en,
    output logic [1:0]      amp_bias,
    output logic [1:0]      drv_bias,
    output logic            input_termination_low,
    output stage_t          stage,
    output logic            config_ready
);

    localparam int PW = $clog2(POR_CYCLES + 1);
    localparam int DW = $clog2(DEGLITCH_CYCLES + 1);

    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [9:0] meta_q;
    logic [9:0] sync_q;
    logic       sck_d_q;
    logic       sen_d_q;
    logic       sck_rise;
    logic       sen_fall;
    logic       sen_rise;
    logic       sdi_s;
    logic [6:0] gain_pins_s;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= `VGA_SYNC_RST;
            sync_q <= `VGA_SYNC_RST;
        end else if (clk_en) begin
            meta_q <= {gain_pins, sdi, sen_n, sck};
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_d_q <= 1'b0;
            sen_d_q <= 1'b1;
        end else if (clk_en) begin
            sck_d_q <= sync_q[0];
            sen_d_q <= sync_q[1];
        end
    end

    assign sck_rise    = sync_q[0] & ~sck_d_q;
    assign sen_fall    = ~sync_q[1] & sen_d_q;
    assign sen_rise    = sync_q[1] & ~sen_d_q;
    assign sdi_s       = sync_q[2];
    assign gain_pins_s = sync_q[9:3];

    // ------------------------------------------------------------------
    // link state machine and power-on wait
    // ------------------------------------------------------------------
    link_state_t     st_q;
    logic [PW-1:0]   por_cnt_q;
    logic            config_ready_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q           <= ST_POR;
            por_cnt_q      <= '0;
            config_ready_q <= 1'b0;
        end else if (clk_en) begin
            case (st_q)
                ST_POR: begin
                    por_cnt_q <= por_cnt_q + 1'b1;
                    if (por_cnt_q == PW'(POR_CYCLES - 1)) begin // R21
                        st_q           <= ST_IDLE;
                        config_ready_q <= 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (sen_fall) begin
                        st_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (sen_rise) begin
                        st_q <= ST_COMMIT; // R23
                    end
                end
                ST_COMMIT: st_q <= ST_IDLE;
                default:   st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // serial shift-in, msb first
    // ------------------------------------------------------------------
    logic [31:0] shift_q;
    logic [5:0]  bit_cnt_q;
    logic [23:0] wdata;
    logic [4:0]  waddr;
    logic        frame_ok;
    logic        wr_en;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_q   <= '0;
            bit_cnt_q <= '0;
        end else if (clk_en) begin
            if (st_q == ST_IDLE && sen_fall) begin
                bit_cnt_q <= '0;
            end else if (st_q == ST_SHIFT && sck_rise) begin
                shift_q <= {shift_q[30:0], sdi_s}; // R22
                if (bit_cnt_q != `VGA_FRAME_BITS) begin
                    bit_cnt_q <= bit_cnt_q + 1'b1;
                end
            end
        end
    end

    assign wdata    = shift_q[31:`VGA_DATA_LSB];
    assign waddr    = shift_q[`VGA_DATA_LSB-1:`VGA_ADDR_LSB];
    assign frame_ok = (bit_cnt_q == `VGA_FRAME_BITS) && (shift_q[2:0] == `VGA_CHIP_ADDR); // R22
    assign wr_en    = clk_en && (st_q == ST_COMMIT) && frame_ok;

    // ------------------------------------------------------------------
    // register file with soft reset
    // ------------------------------------------------------------------
    enables_t   en_q;
    settings_t  set_q;
    logic [8:0] gain_q;
    logic [4:0] rd_addr_q;
    logic       sr_armed_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_q       <= `VGA_EN_RST;
            set_q      <= `VGA_SET_RST;
            gain_q     <= `VGA_GAIN_RST;
            rd_addr_q  <= `VGA_RDADDR_RST;
            sr_armed_q <= 1'b0;
        end else if (wr_en) begin
            case (waddr)
                `VGA_REG_CTRL: begin
                    rd_addr_q  <= wdata[4:0];
                    sr_armed_q <= (wdata == `VGA_SR_ARM);
                    if (sr_armed_q && wdata == `VGA_SR_FIRE) begin // R21
                        en_q      <= `VGA_EN_RST;
                        set_q     <= `VGA_SET_RST;
                        gain_q    <= `VGA_GAIN_RST;
                        rd_addr_q <= `VGA_RDADDR_RST;
                    end
                end
                `VGA_REG_EN:   en_q   <= wdata[1:0]; // R2 R3 R24
                `VGA_REG_SET:  set_q  <= wdata[7:0]; // R4 R6 R8 R9 R10 R11 R24
                `VGA_REG_GAIN: gain_q <= wdata[8:0]; // R13 R15 R24
                default:       sr_armed_q <= sr_armed_q; // R1
            endcase
        end
    end

    assign i_chan_en             = en_q.i_en;
    assign q_chan_en             = en_q.q_en;
    assign amp_bias              = set_q.amp_bias;
    assign drv_bias              = set_q.drv_bias;
    assign input_termination_low = set_q.input_termination_low;
    assign config_ready          = config_ready_q;

    // ------------------------------------------------------------------
    // readback on the next frame
    // ------------------------------------------------------------------
    logic [23:0] rdata;
    logic [31:0] out_q;
    logic        sdo_oe_q;

    always_comb begin
        case (rd_addr_q)
            `VGA_REG_CTRL: rdata = {19'h0_0000, rd_addr_q};
            `VGA_REG_EN:   rdata = {22'h00_0000, en_q}; // R24
            `VGA_REG_SET:  rdata = {16'h0000, set_q};
            `VGA_REG_GAIN: rdata = {15'h0000, gain_q};
            default:       rdata = 24'h00_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_q    <= '0;
            sdo_oe_q <= 1'b0;
        end else if (clk_en) begin
            if (st_q == ST_IDLE && sen_fall) begin
                out_q    <= {rdata, rd_addr_q, `VGA_CHIP_ADDR};
                sdo_oe_q <= 1'b1;
            end else if (st_q == ST_SHIFT) begin
                if (sen_rise) begin
                    sdo_oe_q <= 1'b0;
                end else if (sck_rise && bit_cnt_q != 6'h00) begin
                    out_q <= {out_q[30:0], 1'b0};
                end
            end else begin
                sdo_oe_q <= 1'b0;
            end
        end
    end

    assign sdo_o  = out_q[31];
    assign sdo_oe = sdo_oe_q;

    // ------------------------------------------------------------------
    // gain source selection and decode
    // ------------------------------------------------------------------
    logic [6:0] dec_code;
    stage_t     dec_stage;
    stage_t     target;

    assign dec_code = set_q.gain_from_spi ? gain_q[6:0] : gain_pins_s; // R9 R12 R19

    gain_decoder gain_decoder_inst (
        .code  (dec_code),
        .stage (dec_stage)
    );

    always_comb begin
        if (set_q.gain_from_spi && set_q.bypass_decode) begin
            target = stage_t'(gain_q); // R10 R15 R16 R17 R18
        end else begin
            target = dec_stage; // R13 R19
        end
    end

    // ------------------------------------------------------------------
    // deglitcher: code must hold steady before it is applied
    // ------------------------------------------------------------------
    stage_t        cand_q;
    stage_t        stage_q;
    logic [DW-1:0] dg_cnt_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cand_q   <= '0;
            stage_q  <= '0;
            dg_cnt_q <= '0;
        end else if (clk_en) begin
            cand_q <= target;
            if (set_q.drop_deglitch) begin
                stage_q  <= target; // R11
                dg_cnt_q <= '0;
            end else if (target != cand_q) begin
                dg_cnt_q <= '0;
            end else if (dg_cnt_q == DW'(DEGLITCH_CYCLES - 1)) begin
                stage_q <= cand_q; // R11
            end else begin
                dg_cnt_q <= dg_cnt_q + 1'b1;
            end
        end
    end

    assign stage = stage_q; // R14

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    function automatic logic [6:0] stage_total(input stage_t s);
        logic [6:0] t;
        t = {2'b00, s.s2_half_db};
        if (s.s3_10db) begin
            t = t + `VGA_S3_10DB_HALF;
        end
        if (s.s1_sel == `VGA_S1_20DB) begin
            t = t + `VGA_S1_20DB_HALF;
        end else if (s.s1_sel == `VGA_S1_10DB) begin
            t = t + `VGA_S1_10DB_HALF;
        end
        return t;
    endfunction

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_wr(logic [4:0] a);
        wr_en && waddr == a;
    endsequence

    sequence s_no_commit;
        clk_en && st_q != ST_COMMIT;
    endsequence

    property p_en_write;
        s_wr(`VGA_REG_EN) |=> en_q == $past(wdata[1:0]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost"); // R2 R3

    property p_set_write;
        s_wr(`VGA_REG_SET) |=> set_q == $past(wdata[7:0]);
    endproperty
    a_set_write: assert property (p_set_write) else $error("settings write lost"); // R4 R6 R8

    property p_frame_end_only;
        s_no_commit |=> $stable(en_q) && $stable(set_q) && $stable(gain_q);
    endproperty
    a_frame_end_only: assert property (p_frame_end_only) else $error("register moved mid frame"); // R23

    property p_other_addr;
        clk_en && st_q == ST_COMMIT && (!frame_ok || waddr > `VGA_REG_GAIN)
            |=> $stable(en_q) && $stable(set_q) && $stable(gain_q);
    endproperty
    a_other_addr: assert property (p_other_addr) else $error("stray write took effect"); // R1 R22

    property p_soft_reset;
        s_wr(`VGA_REG_CTRL) ##0 (wdata == `VGA_SR_FIRE && sr_armed_q)
            |=> en_q == `VGA_EN_RST && set_q == `VGA_SET_RST && gain_q == `VGA_GAIN_RST;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset failed"); // R21

    property p_decode_total;
        stage_total(dec_stage) == ((dec_code > `VGA_GAIN_MAX) ? `VGA_GAIN_MAX : dec_code);
    endproperty
    a_decode_total: assert property (p_decode_total) else $error("decoded gain wrong"); // R13

    property p_bypass;
        clk_en && set_q.gain_from_spi && set_q.bypass_decode && set_q.drop_deglitch
            |=> stage_q == stage_t'($past(gain_q));
    endproperty
    a_bypass: assert property (p_bypass) else $error("raw gain not applied"); // R15 R16 R17 R18

    property p_pins_ignore_reg;
        clk_en && !set_q.gain_from_spi && set_q.drop_deglitch
            |=> stage_total(stage_q) == (($past(gain_pins_s) > `VGA_GAIN_MAX) ?
                `VGA_GAIN_MAX : $past(gain_pins_s));
    endproperty
    a_pins_ignore_reg: assert property (p_pins_ignore_reg) else $error("pin gain wrong"); // R12 R19

    property p_deglitch_hold;
        clk_en && !set_q.drop_deglitch && target != cand_q |=> $stable(stage_q);
    endproperty
    a_deglitch_hold: assert property (p_deglitch_hold) else $error("glitch passed"); // R11

    property p_sdo_window;
        clk_en && st_q == ST_IDLE && sen_fall |=> sdo_oe_q && out_q[2:0] == `VGA_CHIP_ADDR;
    endproperty
    a_sdo_window: assert property (p_sdo_window) else $error("readback not driven"); // R22

endmodule

// >>> spi_host_model.sv
// host controller model driving the four-wire serial port of the register bank
`timescale 1ns/1ps

module spi_host_model (
    output logic      sck,
    output logic      sen_n,
    output logic      sdi,
    input  wire logic sdo
);
    // ------------------------------------------------------------------
    // link timing: 125 ns serial clock, idle low between frames
    // ------------------------------------------------------------------
    localparam realtime HALF = 62.5;
    localparam realtime GAP  = 200.0;

    initial begin
        sck   = 1'b0;
        sen_n = 1'b1;
        sdi   = 1'b0;
    end

    // ------------------------------------------------------------------
    // one 32-bit frame: 24 data, 5 address, 3 chip bits, msb first
    // ------------------------------------------------------------------
    task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
        // odd offset keeps link edges away from the system clock edges
        #1.3;
        sen_n <= 1'b0;
        sdi   <= tx[31];
        for (int i = 31; i >= 0; i--) begin
            #HALF;
            sck <= 1'b1;
            #HALF;
            sck <= 1'b0;
            // device answers on the rising edge, host reads on the falling one
            rx[i] = sdo;
            if (i > 0) begin
                sdi <= tx[i - 1];
            end
        end
        #HALF;
        sen_n <= 1'b1;
        // released data line: show the inverse of the last bit
        sdi   <= ~tx[0];
        #GAP;
    endtask
endmodule

// >>> vga_gain_config_registers_test.sv
// self-checking testbench for the gain configuration register bank
`timescale 1ns/1ps
`include "vga_params.svh"

module vga_gain_config_registers_test
    import vga_pkg::*;
;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    localparam int LIMIT = 50000;

    logic       clock;
    logic       rst_n;
    logic       clk_en;
    logic       sck;
    logic       sen_n;
    logic       sdi;
    logic [6:0] gain_pins;
    logic       sdo_o;
    logic       sdo_oe;
    logic       sdo_line;
    logic       i_chan_en;
    logic       q_chan_en;
    logic [1:0] amp_bias;
    logic [1:0] drv_bias;
    logic       input_termination_low;
    stage_t     stage;
    logic       config_ready;
    int         errors;
    int         comparisons;
    int         cycles;
    logic [6:0] codes [11] = '{7'h00, 7'h01, 7'h13, 7'h14, 7'h27, 7'h28,
                               7'h3b, 7'h3c, 7'h4f, 7'h50, 7'h7f};
    logic [8:0] raws  [3]  = '{9'h020, 9'h153, 9'h08a};
    logic [23:0] dflt [5]  = '{24'h00_0000, 24'h00_0003, 24'h00_0015,
                               24'h00_0000, 24'h00_0000};

    // undriven readback line floats
    assign sdo_line = sdo_oe ? sdo_o : 1'bz;

    vga_gain_config_registers #(
        .POR_CYCLES (20)
    ) vga_gain_config_registers_inst (
        .clock                 (clock),
        .rst_n                 (rst_n),
        .clk_en                (clk_en),
        .sck                   (sck),
        .sen_n                 (sen_n),
        .sdi                   (sdi),
        .gain_pins             (gain_pins),
        .sdo_o                 (sdo_o),
        .sdo_oe                (sdo_oe),
        .i_chan_en             (i_chan_en),
        .q_chan_en             (q_chan_en),
        .amp_bias              (amp_bias),
        .drv_bias              (drv_bias),
        .input_termination_low (input_termination_low),
        .stage                 (stage),
        .config_ready          (config_ready)
    );

    spi_host_model spi_host_model_inst (
        .sck   (sck),
        .sen_n (sen_n),
        .sdi   (sdi),
        .sdo   (sdo_line)
    );

    // ------------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        errors      = 0;
        comparisons = 0;
        cycles      = 0;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run;
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // expected stage split of a half-dB code
    function automatic logic [8:0] dec(input logic [6:0] c);
        int         r;
        logic [2:0] s1;
        logic       s3;
        r = (c > 7'h50) ? 80 : int'(c);
        if (r >= 40) begin
            s1 = 3'h4;
            r -= 40;
        end else if (r >= 20) begin
            s1 = 3'h2;
            r -= 20;
        end else begin
            s1 = 3'h1;
        end
        s3 = (r >= 20);
        if (s3) begin
            r -= 20;
        end
        return {s3, s1, 5'(r)};
    endfunction

    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        logic [31:0] rx;
        spi_host_model_inst.frame({d, a, `VGA_CHIP_ADDR}, rx);
    endtask

    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        logic [31:0] rx;
        spi_host_model_inst.frame({19'h0_0000, a, `VGA_REG_CTRL, `VGA_CHIP_ADDR}, rx);
        spi_host_model_inst.frame({19'h0_0000, a, `VGA_REG_CTRL, `VGA_CHIP_ADDR}, rx);
        check(rx[7:0], {a, `VGA_CHIP_ADDR});
        d = rx[31:8];
    endtask

    task automatic pins(input logic [6:0] c);
        @(posedge clock);
        gain_pins <= c;
        repeat (12) @(posedge clock);
        check(stage, dec(c));
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [23:0] d;
        logic [31:0] rx;
        logic [4:0]  v;
        rst_n     = 1'b0;
        clk_en    = 1'b1;
        gain_pins = 7'h00;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check(config_ready, 1'b0);
        check({i_chan_en, q_chan_en}, 2'h3);
        check({input_termination_low, drv_bias, amp_bias}, 5'h15);
        wr(`VGA_REG_EN, 24'h00_0000);
        check(config_ready, 1'b1);
        check({i_chan_en, q_chan_en}, 2'h3);
        for (int a = 1; a < 5; a++) begin
            rd(5'(a), d);
            check(d, dflt[a]);
        end
        wr(`VGA_REG_EN, 24'hff_fffe);
        check({i_chan_en, q_chan_en}, 2'h1);
        rd(`VGA_REG_EN, d);
        check(d, 24'h00_0002);
        wr(`VGA_REG_EN, 24'h00_0001);
        check({i_chan_en, q_chan_en}, 2'h2);
        for (int k = 0; k < 4; k++) begin
            v = {k[0], k[1:0], k[1:0]};
            wr(`VGA_REG_SET, {19'h0_0000, v});
            check({input_termination_low, drv_bias, amp_bias}, v);
        end
        wr(`VGA_REG_SET, 24'h00_004a);
        wr(`VGA_REG_GAIN, 24'h00_0155);
        foreach (codes[i]) pins(codes[i]);
        @(posedge clock);
        gain_pins <= 7'h33;
        wr(`VGA_REG_SET, 24'h00_002a);
        foreach (codes[i]) begin
            wr(`VGA_REG_GAIN, {15'h7fff, 2'h0, codes[i]});
            check(stage, dec(codes[i]));
        end
        wr(`VGA_REG_SET, 24'h00_006a);
        foreach (raws[i]) begin
            wr(`VGA_REG_GAIN, {15'h0000, raws[i]});
            check(stage, raws[i]);
        end
        wr(`VGA_REG_SET, 24'h00_00ea);
        wr(`VGA_REG_GAIN, 24'h00_0185);
        check(stage, 9'h185);
        wr(`VGA_REG_SET, 24'h00_008a);
        pins(7'h2d);
        rd(`VGA_REG_SET, d);
        check(d, 24'h00_008a);
        wr(`VGA_REG_CTRL, 24'h00_0020);
        wr(`VGA_REG_CTRL, 24'h00_0001);
        wr(`VGA_REG_CTRL, 24'h00_0000);
        check({input_termination_low, drv_bias, amp_bias}, 5'h0a);
        wr(`VGA_REG_CTRL, 24'h00_0020);
        wr(`VGA_REG_CTRL, 24'h00_0000);
        check({input_termination_low, drv_bias, amp_bias}, 5'h15);
        check({i_chan_en, q_chan_en}, 2'h3);
        rd(`VGA_REG_GAIN, d);
        check(d, 24'h00_0000);
        spi_host_model_inst.frame({24'h00_0000, `VGA_REG_EN, 3'h5}, rx);
        check({i_chan_en, q_chan_en}, 2'h3);
        fork
            wr(`VGA_REG_EN, 24'h00_0000);
            begin
                repeat (300) @(posedge clock);
                check({i_chan_en, q_chan_en}, 2'h3);
            end
        join
        check({i_chan_en, q_chan_en}, 2'h0);
        @(posedge clock);
        clk_en <= 1'b0;
        wr(`VGA_REG_EN, 24'h00_0003);
        check({i_chan_en, q_chan_en}, 2'h0);
        @(posedge clock);
        clk_en <= 1'b1;
        wr(`VGA_REG_EN, 24'h00_0001);
        check({i_chan_en, q_chan_en}, 2'h2);
        complete_run();
    end
endmodule
